// File: shared/guest_mt_dbg_regs.svh
// constants for the per-thread root/guest context and trap selection logic
// assumes one core clock, synchronous reset, issue and control from the pipeline
//
// Function
// RULE1: third config register reports multithreading presence
// RULE2: each thread owns registers and control context
// RULE3: root/guest contexts per thread, general registers shared
// RULE4: per-thread guest mode; root reports both extensions
// RULE5: guest field zero: threading instructions reserved-trap
// RULE6: guest context never holds threading control registers
// RULE7: guest field one: sensitive-instruction trap to root
// RULE8: guest k/s/u only; debug exists in root
// RULE9: debug mode and guest mode never coexist
// RULE10: debug mode grants full root access
// RULE11: contexts follow the issuing thread every cycle
`ifndef GUEST_MT_DBG_REGS_SVH
`define GUEST_MT_DBG_REGS_SVH

`define THREAD_ID_W        3
`define MAX_THREADS        8
`define GUEST_MT_FIELD_RST 1'b0
`define GUEST_MODE_RST     1'b0
`define DEBUG_MODE_RST     1'b0

`endif

// File: shared/guest_mt_dbg_pkg.sv
// types for the per-thread root/guest context and trap selection logic
// assumes the constants header sits next to this package
`default_nettype none
`include "guest_mt_dbg_regs.svh"

package guest_mt_dbg_pkg;

	typedef logic [`THREAD_ID_W-1:0] tid_t;

	// guest has exactly these three; debug is a separate root-only bit
	typedef enum logic [1:0] {
		PRIV_KERNEL,
		PRIV_SUPER,
		PRIV_USER
	} priv_t;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_MT_INSN,
		OP_CTL_MOVE_TO,
		OP_CTL_MOVE_FROM
	} op_t;

	typedef enum logic [1:0] {
		TRAP_NONE,
		TRAP_RESERVED_INSN,
		TRAP_GUEST_SENSITIVE
	} trap_kind_t;

	// one instruction at issue
	typedef struct packed {
		logic valid;
		tid_t tid;
		op_t  op;
		logic cr_is_mt;
	} issue_t;

	// control events aimed at one thread
	typedef struct packed {
		logic  valid;
		tid_t  tid;
		logic  enter_guest;
		logic  exit_guest;
		logic  debug_enter;
		logic  debug_exit;
		logic  set_guest_priv;
		priv_t guest_priv;
		logic  set_root_priv;
		priv_t root_priv;
		logic  wr_guest_mt;
		logic  guest_mt_val;
	} ctl_t;

	typedef struct packed {
		logic  guest_mode;
		priv_t guest_priv;
		priv_t root_priv;
		logic  debug;
		logic  resume_guest;
		logic  guest_mt_field;
	} thread_ctx_t;

	// selected context of the issuing thread
	typedef struct packed {
		logic  valid;
		tid_t  tid;
		logic  guest_active;
		priv_t guest_priv;
		priv_t root_priv;
		logic  debug;
		logic  root_full_access;
		logic  cr_block;
	} ctx_sel_t;

	typedef struct packed {
		trap_kind_t kind;
		tid_t       tid;
	} trap_out_t;

	typedef struct packed {
		logic multithread_present_field;
		logic virtualization_present_field;
	} cfg3_t;

endpackage : guest_mt_dbg_pkg

`default_nettype wire

// File: hw/mt_trap_classify.sv
// trap and blocking decision for one issued instruction
// assumes its inputs are the selected thread's live context
`timescale 1ns/1ps
`default_nettype none

module mt_trap_classify
	import guest_mt_dbg_pkg::*;
(
	input  wire logic       i_guest_active,
	input  wire priv_t      i_guest_priv,
	input  wire logic       i_guest_mt_field,
	input  wire op_t        i_op,
	input  wire logic       i_cr_is_mt,
	output var  trap_kind_t o_trap,
	output var  logic       o_cr_block
);

	// control move touching a threading register
	function automatic logic is_mt_move(input op_t op, input logic cr_mt);
		is_mt_move = cr_mt && (op == OP_CTL_MOVE_TO || op == OP_CTL_MOVE_FROM);
	endfunction : is_mt_move

	// only guest execution is screened; root runs threading ops natively
	always_comb
	begin
		o_trap     = TRAP_NONE;
		o_cr_block = 1'b0;
		if (i_guest_active)
		begin
			// guest context has no threading registers to reach [RULE6]
			o_cr_block = is_mt_move(i_op, i_cr_is_mt);
			if (i_guest_mt_field)
			begin
				// root emulates: hand threading instructions and kernel-level threading moves to root [RULE7]
				if (i_op == OP_MT_INSN)
					o_trap = TRAP_GUEST_SENSITIVE;
				else if (is_mt_move(i_op, i_cr_is_mt) && i_guest_priv == PRIV_KERNEL)
					o_trap = TRAP_GUEST_SENSITIVE;
			end
			else if (i_op == OP_MT_INSN)
				o_trap = TRAP_RESERVED_INSN; // moves stay untrapped, result undefined [RULE5]
		end
	end

endmodule : mt_trap_classify

`default_nettype wire

// File: hw/guest_mt_debug_privilege_ctl.sv
// per-thread root/guest context selection, threading traps, debug exclusion
// assumes issue and control structs come from pipeline logic on i_clk
`timescale 1ns/1ps
`default_nettype none
`include "guest_mt_dbg_regs.svh"

module guest_mt_debug_privilege_ctl
	import guest_mt_dbg_pkg::*;
#(
	parameter int  N_THREADS = 3,
	parameter bit  MT_IMPL   = 1'b1,
	parameter bit  VZ_IMPL   = 1'b1
)
(
	input  wire logic      i_clk,
	input  wire logic      i_rst,
	input  wire issue_t    i_issue,
	input  wire ctl_t      i_ctl,
	output var  ctx_sel_t  o_sel,
	output var  trap_out_t o_trap,
	output var  tid_t      o_gpr_bank,
	output var  cfg3_t     o_root_cfg3,
	output var  cfg3_t     o_guest_cfg3
);

	// refuse thread counts the id field cannot address
	if (N_THREADS < 1 || N_THREADS > `MAX_THREADS)
	begin : g_bad_threads
		$error("N_THREADS out of range");
	end

	typedef struct packed {
		thread_ctx_t [N_THREADS-1:0] thr;
		ctx_sel_t                    sel;
		trap_out_t                   trap;
		tid_t                        gpr_bank;
		cfg3_t                       rcfg;
		cfg3_t                       gcfg;
	} state_t;

	state_t      st_r;
	state_t      st_nxt;
	thread_ctx_t cur;
	thread_ctx_t cur_nxt;
	logic        issue_ok;
	logic        ctl_ok;
	trap_kind_t  trap_kind;
	logic        cr_block;

	// thread id in range for this build
	// out-of-range ids are dropped, never folded onto a real thread
	function automatic logic tid_ok(input tid_t t);
		tid_ok = (32'(t) < N_THREADS);
	endfunction : tid_ok

	assign issue_ok = i_issue.valid && tid_ok(i_issue.tid);
	assign ctl_ok   = i_ctl.valid && tid_ok(i_ctl.tid);

	// context of the issuing thread, as it stands this cycle [RULE11]
	always_comb
	begin
		cur = '0;
		if (issue_ok)
			cur = st_r.thr[i_issue.tid];
	end

	mt_trap_classify u_classify (
		.i_guest_active   (issue_ok && cur.guest_mode && !cur.debug),
		.i_guest_priv     (cur.guest_priv),
		.i_guest_mt_field (cur.guest_mt_field),
		.i_op             (issue_ok ? i_issue.op : OP_NONE),
		.i_cr_is_mt       (i_issue.cr_is_mt),
		.o_trap           (trap_kind),
		.o_cr_block       (cr_block)
	);

	// next state: thread contexts, then the selected view
	always_comb
	begin
		st_nxt  = st_r;
		cur_nxt = '0;
		// control events touch only the addressed thread [RULE2]
		if (ctl_ok)
		begin
			cur_nxt = st_r.thr[i_ctl.tid];
			// event priority: debug entry, debug exit, guest entry, guest exit
			if (i_ctl.debug_enter)
			begin
				// leaving guest on debug entry, remember to come back [RULE9]
				cur_nxt.resume_guest = cur_nxt.guest_mode;
				cur_nxt.guest_mode   = 1'b0;
				cur_nxt.debug        = 1'b1;
			end
			else if (i_ctl.debug_exit && cur_nxt.debug)
			begin
				cur_nxt.debug        = 1'b0;
				cur_nxt.guest_mode   = cur_nxt.resume_guest;
				cur_nxt.resume_guest = 1'b0;
			end
			else if (i_ctl.enter_guest && !cur_nxt.debug)
				cur_nxt.guest_mode = VZ_IMPL; // guest entry refused in debug [RULE9] [RULE4]
			else if (i_ctl.exit_guest)
				cur_nxt.guest_mode = 1'b0;
			// writes of level code 3 are dropped, so an illegal level cannot be stored [RULE8]
			if (i_ctl.set_guest_priv && i_ctl.guest_priv != 2'h3)
				cur_nxt.guest_priv = i_ctl.guest_priv;
			if (i_ctl.set_root_priv && i_ctl.root_priv != 2'h3)
				cur_nxt.root_priv = i_ctl.root_priv;
			// root-writable guest presence field for emulation [RULE7]
			if (i_ctl.wr_guest_mt)
				cur_nxt.guest_mt_field = i_ctl.guest_mt_val;
			st_nxt.thr[i_ctl.tid] = cur_nxt;
		end
		// selected view; general bank follows thread, not root/guest [RULE3]
		st_nxt.sel.valid        = issue_ok;
		st_nxt.sel.tid          = issue_ok ? i_issue.tid : '0;
		st_nxt.sel.guest_active = cur.guest_mode && !cur.debug; // [RULE9]
		st_nxt.sel.guest_priv   = cur.guest_priv;
		st_nxt.sel.root_priv    = cur.root_priv;
		st_nxt.sel.debug        = cur.debug;
		st_nxt.sel.root_full_access = cur.debug ||
			(!cur.guest_mode && cur.root_priv == PRIV_KERNEL); // [RULE10]
		st_nxt.sel.cr_block     = cr_block; // [RULE6]
		st_nxt.gpr_bank         = issue_ok ? i_issue.tid : st_r.gpr_bank; // [RULE2] [RULE3]
		st_nxt.trap.kind        = trap_kind; // [RULE5] [RULE7]
		st_nxt.trap.tid         = issue_ok ? i_issue.tid : '0;
		// presence fields: root sees both extensions [RULE1] [RULE4]
		st_nxt.rcfg.multithread_present_field    = MT_IMPL;
		st_nxt.rcfg.virtualization_present_field = VZ_IMPL;
		// guest never sees nested virtualization; threading only as emulated
		st_nxt.gcfg.multithread_present_field    = cur.guest_mt_field;
		st_nxt.gcfg.virtualization_present_field = 1'b0;
	end

	// every thread resets to root kernel, outside guest and debug
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			st_r <= '0;
			for (int t = 0; t < N_THREADS; t++)
			begin
				st_r.thr[t].guest_mode     <= `GUEST_MODE_RST;
				st_r.thr[t].debug          <= `DEBUG_MODE_RST;
				st_r.thr[t].guest_mt_field <= `GUEST_MT_FIELD_RST;
				st_r.thr[t].root_priv      <= PRIV_KERNEL;
				st_r.thr[t].guest_priv     <= PRIV_KERNEL;
			end
		end
		else
			st_r <= st_nxt;
	end

	// outputs straight from the state flops
	assign o_sel        = st_r.sel;
	assign o_trap       = st_r.trap;
	assign o_gpr_bank   = st_r.gpr_bank;
	assign o_root_cfg3  = st_r.rcfg;
	assign o_guest_cfg3 = st_r.gcfg;

	// per-thread exclusion of guest and debug held in every context
	// checks repeat per thread so a fault names the context it hit
	for (genvar g = 0; g < N_THREADS; g++)
	begin : g_thr_chk
		a_thr_debug_excl: assert property ( // [RULE9]
			@(posedge i_clk) disable iff (i_rst)
			!(st_r.thr[g].debug && st_r.thr[g].guest_mode))
			else $error("thread in guest and debug at once");

		// events aimed elsewhere leave this context alone
		a_thr_isolated: assert property ( // [RULE2]
			@(posedge i_clk) disable iff (i_rst)
			!(ctl_ok && i_ctl.tid == tid_t'(g)) |=> st_r.thr[g] == $past(st_r.thr[g]))
			else $error("thread context changed by another thread");

		// level code 3 never lands in either context
		a_thr_priv_legal: assert property ( // [RULE8]
			@(posedge i_clk) disable iff (i_rst)
			st_r.thr[g].guest_priv != 2'h3 && st_r.thr[g].root_priv != 2'h3)
			else $error("illegal privilege level stored");

		a_thr_root_priv: assert property ( // [RULE8]
			@(posedge i_clk) disable iff (i_rst)
			ctl_ok && i_ctl.tid == tid_t'(g) && i_ctl.set_root_priv &&
			i_ctl.root_priv != 2'h3 |=> st_r.thr[g].root_priv == $past(i_ctl.root_priv))
			else $error("root level write lost");

		// plain guest exit when nothing of higher priority is asked
		a_thr_guest_exit: assert property ( // [RULE4]
			@(posedge i_clk) disable iff (i_rst)
			ctl_ok && i_ctl.tid == tid_t'(g) && i_ctl.exit_guest &&
			!i_ctl.enter_guest && !i_ctl.debug_exit |=> !st_r.thr[g].guest_mode)
			else $error("guest mode kept after exit");
	end

	a_sel_debug_excl: assert property ( // [RULE9]
		@(posedge i_clk) disable iff (i_rst)
		o_sel.debug |-> !o_sel.guest_active)
		else $error("guest shown active in debug");

	a_debug_full_access: assert property ( // [RULE10]
		@(posedge i_clk) disable iff (i_rst)
		o_sel.valid && o_sel.debug |-> o_sel.root_full_access)
		else $error("debug lacks root access");

	a_ri_mt_absent: assert property ( // [RULE5]
		@(posedge i_clk) disable iff (i_rst)
		issue_ok && cur.guest_mode && !cur.guest_mt_field && i_issue.op == OP_MT_INSN
		|=> o_trap.kind == TRAP_RESERVED_INSN && o_trap.tid == $past(i_issue.tid))
		else $error("missing reserved trap");

	a_guest_sensitive_instruction_trap_mt_emul: assert property ( // [RULE7]
		@(posedge i_clk) disable iff (i_rst)
		issue_ok && cur.guest_mode && cur.guest_mt_field &&
		(i_issue.op == OP_MT_INSN ||
		 (i_issue.cr_is_mt && cur.guest_priv == PRIV_KERNEL && i_issue.op == OP_CTL_MOVE_TO))
		|=> o_trap.kind == TRAP_GUEST_SENSITIVE)
		else $error("missing sensitive trap");

	a_root_no_trap: assert property ( // [RULE4]
		@(posedge i_clk) disable iff (i_rst)
		issue_ok && !cur.guest_mode |=> o_trap.kind == TRAP_NONE)
		else $error("root op trapped");

	a_mt_reg_blocked: assert property ( // [RULE6]
		@(posedge i_clk) disable iff (i_rst)
		issue_ok && cur.guest_mode && !cur.debug && i_issue.cr_is_mt &&
		i_issue.op == OP_CTL_MOVE_FROM |=> o_sel.cr_block)
		else $error("guest reached threading register");

	a_cfg_present: assert property ( // [RULE1]
		@(posedge i_clk) disable iff (i_rst)
		$past(i_rst) |=> o_root_cfg3.multithread_present_field == MT_IMPL &&
		o_root_cfg3.virtualization_present_field == VZ_IMPL)
		else $error("presence fields wrong");

	a_guest_priv_legal: assert property ( // [RULE8]
		@(posedge i_clk) disable iff (i_rst)
		o_sel.guest_active |-> o_sel.guest_priv inside {PRIV_KERNEL, PRIV_SUPER, PRIV_USER})
		else $error("illegal guest level");

	a_thread_select: assert property ( // [RULE11]
		@(posedge i_clk) disable iff (i_rst)
		issue_ok |=> o_sel.valid && o_sel.tid == $past(i_issue.tid) &&
		o_gpr_bank == $past(i_issue.tid))
		else $error("wrong thread selected");

	a_debug_blocks_entry: assert property ( // [RULE9]
		@(posedge i_clk) disable iff (i_rst)
		ctl_ok && i_ctl.debug_enter |=> !st_r.thr[$past(i_ctl.tid)].guest_mode)
		else $error("guest kept across debug entry");

	// no issue: selected view and trap go quiet
	a_idle_quiet: assert property ( // [RULE11]
		@(posedge i_clk) disable iff (i_rst)
		!issue_ok |=> !o_sel.valid && o_trap.kind == TRAP_NONE)
		else $error("stale selection or trap");

	a_gpr_hold: assert property ( // [RULE2]
		@(posedge i_clk) disable iff (i_rst)
		!issue_ok |=> $stable(o_gpr_bank))
		else $error("register bank moved without issue");

	// field zero: moves are suppressed, never trapped
	a_ri_move_quiet: assert property ( // [RULE5]
		@(posedge i_clk) disable iff (i_rst)
		issue_ok && cur.guest_mode && !cur.guest_mt_field && i_issue.cr_is_mt &&
		(i_issue.op == OP_CTL_MOVE_TO || i_issue.op == OP_CTL_MOVE_FROM)
		|=> o_trap.kind == TRAP_NONE && o_sel.cr_block)
		else $error("threading move trapped or reached");

	a_guest_sensitive_instruction_trap_kernel_read: assert property ( // [RULE7]
		@(posedge i_clk) disable iff (i_rst)
		issue_ok && cur.guest_mode && cur.guest_mt_field &&
		cur.guest_priv == PRIV_KERNEL && i_issue.cr_is_mt &&
		i_issue.op == OP_CTL_MOVE_FROM
		|=> o_trap.kind == TRAP_GUEST_SENSITIVE && o_sel.cr_block)
		else $error("kernel read of threading register not trapped");

	// guest view follows the issuing thread's emulation field
	a_guest_cfg_view: assert property ( // [RULE7]
		@(posedge i_clk) disable iff (i_rst)
		issue_ok |=> o_guest_cfg3.multithread_present_field ==
		$past(cur.guest_mt_field) && !o_guest_cfg3.virtualization_present_field)
		else $error("guest presence view wrong");

	// guest code is never granted root's reach
	a_guest_not_root: assert property ( // [RULE3]
		@(posedge i_clk) disable iff (i_rst)
		o_sel.guest_active |-> !o_sel.root_full_access)
		else $error("guest given root access");

	// guest entry asked during debug stays refused
	a_entry_in_debug: assert property ( // [RULE9]
		@(posedge i_clk) disable iff (i_rst)
		ctl_ok && i_ctl.enter_guest && !i_ctl.debug_enter && !i_ctl.debug_exit &&
		st_r.thr[i_ctl.tid].debug |=> !st_r.thr[$past(i_ctl.tid)].guest_mode)
		else $error("guest entered during debug");

	// both privilege levels shown are the issuing thread's own
	a_sel_levels: assert property ( // [RULE11]
		@(posedge i_clk) disable iff (i_rst)
		issue_ok |=> o_sel.root_priv == $past(cur.root_priv) &&
		o_sel.guest_priv == $past(cur.guest_priv))
		else $error("privilege levels of wrong thread");

endmodule : guest_mt_debug_privilege_ctl

`default_nettype wire

// File: sim/tb.sv
// self-checking bench for the per-thread context and trap selection block
// assumes package and header compile first; the bench drives every port itself
`timescale 1ns/1ps
`default_nettype none

module tb
	import guest_mt_dbg_pkg::*;
;

	logic      i_clk;
	logic      i_rst;
	issue_t    i_issue;
	ctl_t      i_ctl;
	ctx_sel_t  o_sel;
	trap_out_t o_trap;
	tid_t      o_gpr_bank;
	cfg3_t     o_root_cfg3;
	cfg3_t     o_guest_cfg3;
	int        mismatches;
	int        checks;

	guest_mt_debug_privilege_ctl #(
		.N_THREADS (3),
		.MT_IMPL   (1'b1),
		.VZ_IMPL   (1'b1)
	) i_dut (
		.i_clk        (i_clk),
		.i_rst        (i_rst),
		.i_issue      (i_issue),
		.i_ctl        (i_ctl),
		.o_sel        (o_sel),
		.o_trap       (o_trap),
		.o_gpr_bank   (o_gpr_bank),
		.o_root_cfg3  (o_root_cfg3),
		.o_guest_cfg3 (o_guest_cfg3)
	);

	// 4 ns core clock
	initial
	begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	task automatic cmp_bit(input string name, input logic exp, input logic got);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %0b seen %0b", name, exp, got);
		end
	endtask : cmp_bit

	task automatic cmp_v(input string name, input logic [2:0] exp, input logic [2:0] got);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
		end
	endtask : cmp_v

	task automatic cmp_trap(input string name, input trap_kind_t exp, input trap_kind_t got);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
		end
	endtask : cmp_trap

	task automatic cmp_priv(input string name, input priv_t exp, input priv_t got);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
		end
	endtask : cmp_priv

	function automatic ctl_t mk(input tid_t t);
		ctl_t c;
		c = '0;
		c.valid = 1'b1;
		c.tid = t;
		return c;
	endfunction : mk

	// one-cycle event; issue idles so the event is seen alone
	task automatic do_ctl(input ctl_t c);
		i_issue = '0;
		i_ctl = c;
		@(negedge i_clk);
	endtask : do_ctl

	// issue held until the next call, so back-to-back issues never double-drive
	task automatic do_issue(input tid_t t, input op_t o, input logic m);
		i_ctl = '0;
		i_issue = '{valid: 1'b1, tid: t, op: o, cr_is_mt: m};
		@(negedge i_clk);
	endtask : do_issue

	task automatic t_cfg;
		cmp_bit("root mt present", 1'b1, o_root_cfg3.multithread_present_field);
		cmp_bit("root vz present", 1'b1, o_root_cfg3.virtualization_present_field);
		cmp_bit("guest vz", 1'b0, o_guest_cfg3.virtualization_present_field);
		$display("test cfg done");
	endtask : t_cfg

	task automatic t_guest_ri;
		ctl_t c;
		c = mk(3'h1);
		c.enter_guest = 1'b1;
		do_ctl(c);
		do_issue(3'h1, OP_MT_INSN, 1'b0);
		cmp_bit("guest active", 1'b1, o_sel.guest_active);
		cmp_trap("mt insn trap", TRAP_RESERVED_INSN, o_trap.kind);
		cmp_v("trap tid", 3'h1, o_trap.tid);
		cmp_v("gpr bank", 3'h1, o_gpr_bank);
		do_issue(3'h1, OP_CTL_MOVE_TO, 1'b1);
		cmp_trap("move trap", TRAP_NONE, o_trap.kind);
		cmp_bit("move blocked", 1'b1, o_sel.cr_block);
		cmp_bit("guest mt field", 1'b0, o_guest_cfg3.multithread_present_field);
		$display("test guest reserved done");
	endtask : t_guest_ri

	// alternate threads each cycle: guest state follows the issuing thread
	task automatic t_threads;
		do_issue(3'h0, OP_MT_INSN, 1'b0);
		cmp_bit("t0 guest", 1'b0, o_sel.guest_active);
		cmp_trap("t0 trap", TRAP_NONE, o_trap.kind);
		cmp_bit("t0 full access", 1'b1, o_sel.root_full_access);
		do_issue(3'h1, OP_MT_INSN, 1'b0);
		cmp_bit("t1 guest", 1'b1, o_sel.guest_active);
		cmp_trap("t1 trap", TRAP_RESERVED_INSN, o_trap.kind);
		do_issue(3'h5, OP_MT_INSN, 1'b0);
		cmp_bit("bad tid ignored", 1'b0, o_sel.valid);
		cmp_v("gpr held", 3'h1, o_gpr_bank);
		$display("test threads done");
	endtask : t_threads

	task automatic t_guest_sensitive_instruction_trap;
		ctl_t c;
		c = mk(3'h1);
		c.wr_guest_mt = 1'b1;
		c.guest_mt_val = 1'b1;
		do_ctl(c);
		do_issue(3'h1, OP_MT_INSN, 1'b0);
		cmp_trap("emul insn trap", TRAP_GUEST_SENSITIVE, o_trap.kind);
		cmp_bit("guest mt shown", 1'b1, o_guest_cfg3.multithread_present_field);
		do_issue(3'h1, OP_CTL_MOVE_FROM, 1'b1);
		cmp_trap("kernel move trap", TRAP_GUEST_SENSITIVE, o_trap.kind);
		do_issue(3'h1, OP_CTL_MOVE_TO, 1'b0);
		cmp_trap("plain move trap", TRAP_NONE, o_trap.kind);
		cmp_bit("plain move open", 1'b0, o_sel.cr_block);
		do_issue(3'h0, OP_NONE, 1'b0);
		cmp_bit("t0 guest mt", 1'b0, o_guest_cfg3.multithread_present_field);
		$display("test sensitive done");
	endtask : t_guest_sensitive_instruction_trap

	// code 3 must not disturb the user level set just before
	task automatic t_priv;
		ctl_t c;
		c = mk(3'h1);
		c.set_guest_priv = 1'b1;
		c.guest_priv = PRIV_USER;
		do_ctl(c);
		c.guest_priv = priv_t'(2'h3);
		do_ctl(c);
		do_issue(3'h1, OP_CTL_MOVE_TO, 1'b1);
		cmp_priv("guest priv", PRIV_USER, o_sel.guest_priv);
		cmp_trap("user move trap", TRAP_NONE, o_trap.kind);
		cmp_bit("user move blocked", 1'b1, o_sel.cr_block);
		$display("test privilege done");
	endtask : t_priv

	task automatic t_debug;
		ctl_t c;
		c = mk(3'h1);
		c.debug_enter = 1'b1;
		do_ctl(c);
		c = mk(3'h1);
		c.enter_guest = 1'b1;
		do_ctl(c);
		do_issue(3'h1, OP_MT_INSN, 1'b0);
		cmp_bit("debug on", 1'b1, o_sel.debug);
		cmp_bit("guest off in debug", 1'b0, o_sel.guest_active);
		cmp_bit("debug full access", 1'b1, o_sel.root_full_access);
		cmp_trap("debug mt insn", TRAP_NONE, o_trap.kind);
		c = mk(3'h1);
		c.debug_exit = 1'b1;
		do_ctl(c);
		do_issue(3'h1, OP_NONE, 1'b0);
		cmp_bit("debug off", 1'b0, o_sel.debug);
		cmp_bit("guest restored", 1'b1, o_sel.guest_active);
		cmp_bit("guest no full access", 1'b0, o_sel.root_full_access);
		$display("test debug done");
	endtask : t_debug

	// root level and plain guest exit, then a reset in mid-run
	task automatic t_root;
		ctl_t c;
		c = mk(3'h0);
		c.set_root_priv = 1'b1;
		c.root_priv = PRIV_USER;
		do_ctl(c);
		c = mk(3'h1);
		c.exit_guest = 1'b1;
		do_ctl(c);
		do_issue(3'h0, OP_MT_INSN, 1'b0);
		cmp_v("t0 sel tid", 3'h0, o_sel.tid);
		cmp_priv("t0 root priv", PRIV_USER, o_sel.root_priv);
		cmp_bit("root user access", 1'b0, o_sel.root_full_access);
		do_issue(3'h1, OP_MT_INSN, 1'b0);
		cmp_v("t1 sel tid", 3'h1, o_sel.tid);
		cmp_bit("t1 guest exited", 1'b0, o_sel.guest_active);
		cmp_trap("root mt insn", TRAP_NONE, o_trap.kind);
		i_issue = '0;
		i_rst = 1'b1;
		@(negedge i_clk);
		i_rst = 1'b0;
		@(negedge i_clk);
		do_issue(3'h1, OP_MT_INSN, 1'b0);
		cmp_bit("reset leaves guest", 1'b0, o_sel.guest_active);
		cmp_priv("reset root priv", PRIV_KERNEL, o_sel.root_priv);
		cmp_bit("reset guest mt", 1'b0, o_guest_cfg3.multithread_present_field);
		cmp_bit("root mt after reset", 1'b1, o_root_cfg3.multithread_present_field);
		$display("test root and reset done");
	endtask : t_root

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up

	// the tests take under 60 cycles; 400 leaves ample room
	initial
	begin
		#(400 * 4);
		mismatches++;
		wrap_up();
	end

	initial
	begin
		i_rst = 1'b1;
		i_issue = '0;
		i_ctl = '0;
		mismatches = 0;
		checks = 0;
		repeat (2) @(posedge i_clk);
		@(negedge i_clk);
		i_rst = 1'b0;
		@(negedge i_clk);
		t_cfg();
		t_guest_ri();
		t_threads();
		t_guest_sensitive_instruction_trap();
		t_priv();
		t_debug();
		t_root();
		wrap_up();
	end

endmodule : tb

`default_nettype wire
